// ===== acseq_top.sv
// AXI4-Lite controlled sequencer for a 12-bit successive-approximation converter.
// Behaviour
// (RL1) Sample four converter clocks, then convert twelve.
// (RL2) Whole conversion lasts sixteen converter clocks.
// (RL3) Conversion runs in hardware, bus stays free.
// (RL4) Software pulses start high then low.
// (RL5) Busy flag high throughout conversion.
// (RL6) Completion clears busy, exposes result bytes.
// (RL7) Software sets divider before starting.
// (RL8) Internal source disconnects external channel path.
// (RL9) Software configures pin, then channel select.
// (RL10) Software picks reference, enables amplifier when needed.
// (RL11) Result byte layout follows format select.
// (RL12) Interrupt needs global, converter, multifunction enables.
// (RL13) Power enable low switches core off.
// (RL14) Twelve-bit result, full scale all ones.
// (RL15) Tap select low only for LDO source.
// (RL16) Divider selects system clock over power of two.
// (RL17) Source select decodes external/supply/amplifier/LDO.
// (RL18) Completion sets request flag regardless of enables.
// (RL19) Start high holds reset; falling edge launches.
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "acseq_defs.svh"

module acseq_top #(
	parameter int RES_BITS = 12
) (
	input  wire logic                         clk_sys,
	input  wire logic                         reset,
	input  wire logic [7:0]                   s_axi_awaddr,
	input  wire logic                         s_axi_awvalid,
	output logic                              s_axi_awready,
	input  wire logic [31:0]                  s_axi_wdata,
	input  wire logic [3:0]                   s_axi_wstrb,
	input  wire logic                         s_axi_wvalid,
	output logic                              s_axi_wready,
	output logic [1:0]                        s_axi_bresp,
	output logic                              s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	input  wire logic [7:0]                   s_axi_araddr,
	input  wire logic                         s_axi_arvalid,
	output logic                              s_axi_arready,
	output logic [31:0]                       s_axi_rdata,
	output logic [1:0]                        s_axi_rresp,
	output logic                              s_axi_rvalid,
	input  wire logic                         s_axi_rready,
	input  wire logic [RES_BITS-1:0]          core_result,
	output acseq_pkg::acseq_core_ctrl_type    core_ctrl,
	output acseq_pkg::acseq_route_type        route,
	output logic                              irq
);
	import acseq_pkg::*;

	// ****************************************************************
	// Register state
	// ****************************************************************
	logic [7:0]          ctrl0_q;
	logic [7:0]          ctrl1_q;
	logic [7:0]          ctrl2_q;
	logic [7:0]          res_high_q;
	logic [7:0]          res_low_q;
	logic                int_status_q;
	logic                int_mask_q;
	logic [2:0]          int_enable_q;
	logic                start_prev_q;
	acseq_state_type     state_q;
	logic [3:0]          phase_cnt_q;
	logic [6:0]          div_cnt_q;
	logic                busy_q;
	logic                done_q;
	logic                awready_q;
	logic                wready_q;
	logic                bvalid_q;
	logic [1:0]          bresp_q;
	logic                arready_q;
	logic                rvalid_q;
	logic [31:0]         rdata_q;
	logic [1:0]          rresp_q;
	logic [7:0]          aw_addr_q;
	logic [31:0]         w_data_q;
	logic                w_lane0_q;
	acseq_core_ctrl_type core_q;
	acseq_route_type     route_q;
	logic                irq_q;

	logic                start_bit;
	logic                power_bit;
	logic                format_bit;
	logic [2:0]          div_sel;
	logic [6:0]          div_mask;
	logic                tick;
	logic                wr_fire;
	logic                map_hit_w;
	logic                map_hit_r;
	logic                internal_src;

	assign start_bit  = ctrl0_q[`ACSEQ_C0_START];
	assign power_bit  = ctrl0_q[`ACSEQ_C0_POWER];
	assign format_bit = ctrl0_q[`ACSEQ_C0_FORMAT];
	assign div_sel    = ctrl1_q[`ACSEQ_C1_DIV_LSB +: 3];

	// ****************************************************************
	// Converter clock divider
	// ****************************************************************
	// Tick marks the last system clock of each converter clock period.
	assign div_mask = 7'((8'h01 << div_sel) - 8'h01); // RL16
	assign tick     = ((div_cnt_q | ~div_mask) == 7'h7F); // RL16

	// The divider restarts while start is held and until launch, so the first sample period is a full one.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			div_cnt_q <= 7'h00;
		end else if (start_bit || state_q == ACSEQ_IDLE || state_q == ACSEQ_HOLD) begin // RL16
			div_cnt_q <= 7'h00;
		end else begin
			div_cnt_q <= div_cnt_q + 7'h01;
		end
	end

	// ****************************************************************
	// Conversion sequencer
	// ****************************************************************
	// Runs on its own once launched; the bus keeps serving meanwhile.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_q      <= ACSEQ_IDLE;
			phase_cnt_q  <= 4'h0;
			busy_q       <= 1'b0;
			done_q       <= 1'b0;
			start_prev_q <= 1'b0;
		end else begin
			start_prev_q <= start_bit;
			done_q       <= 1'b0;
			if (!power_bit) begin
				// Powering down abandons any conversion in flight.
				state_q <= ACSEQ_IDLE; // RL13
				busy_q  <= 1'b0;
			end else if (start_bit) begin
				state_q     <= ACSEQ_HOLD; // RL19
				phase_cnt_q <= 4'h0;
				busy_q      <= 1'b0;
			end else begin
				case (state_q)
					ACSEQ_HOLD: begin
						if (start_prev_q) begin
							state_q     <= ACSEQ_SAMPLE; // RL19 RL3
							busy_q      <= 1'b1; // RL5
							phase_cnt_q <= 4'h0;
						end else begin
							state_q <= ACSEQ_IDLE;
						end
					end
					ACSEQ_SAMPLE: begin
						if (tick) begin
							if (phase_cnt_q == `ACSEQ_SAMPLE_CYCLES - 4'h1) begin
								state_q     <= ACSEQ_CONVERT; // RL1
								phase_cnt_q <= 4'h0;
							end else begin
								phase_cnt_q <= phase_cnt_q + 4'h1;
							end
						end
					end
					ACSEQ_CONVERT: begin
						if (tick) begin
							if (phase_cnt_q == `ACSEQ_CONVERT_CYCLES - 4'h1) begin
								state_q <= ACSEQ_IDLE; // RL2
								busy_q  <= 1'b0; // RL6
								done_q  <= 1'b1;
							end else begin
								phase_cnt_q <= phase_cnt_q + 4'h1;
							end
						end
					end
					default: begin
						state_q <= ACSEQ_IDLE;
					end
				endcase
			end
		end
	end

	// Result capture; the full-scale code is all ones across the twelve bits.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			res_high_q <= 8'h00;
			res_low_q  <= 8'h00;
		end else if (state_q == ACSEQ_CONVERT && tick && phase_cnt_q == `ACSEQ_CONVERT_CYCLES - 4'h1) begin
			if (format_bit) begin
				res_high_q <= {4'h0, core_result[11:8]}; // RL11 RL14
				res_low_q  <= core_result[7:0];
			end else begin
				res_high_q <= core_result[11:4]; // RL11 RL14
				res_low_q  <= {core_result[3:0], 4'h0};
			end
		end
	end

	// ****************************************************************
	// Core strobes and routing
	// ****************************************************************
	assign internal_src = !(route_q.source == 4'h0 || route_q.source == 4'h4 || route_q.source >= 4'hC);

	// All outputs towards the core are registered so no decode glitch reaches the analog side.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			core_q  <= '0;
			route_q <= '0;
		end else begin
			core_q.power   <= power_bit; // RL13
			core_q.reset   <= start_bit || !power_bit; // RL19
			core_q.sample  <= power_bit && state_q == ACSEQ_SAMPLE;
			core_q.convert <= power_bit && state_q == ACSEQ_CONVERT;
			core_q.tick    <= power_bit && tick;
			route_q.source    <= ctrl1_q[`ACSEQ_C1_SRC_LSB +: 4];
			route_q.channel   <= ctrl0_q[`ACSEQ_C0_CHAN_LSB +: 4];
			route_q.reference <= ctrl2_q[`ACSEQ_C2_REF_LSB +: 2];
			route_q.amp_enable <= ctrl2_q[`ACSEQ_C2_AMP_EN];
			route_q.amp_input  <= ctrl2_q[`ACSEQ_C2_AMP_IN];
			// Codes 0, 4 and C..F carry the external channel; all others are internal.
			route_q.ext_connect <= power_bit && (ctrl1_q[7:4] == 4'h0 || ctrl1_q[7:4] == 4'h4 ||
				ctrl1_q[7:4] >= 4'hC); // RL8 RL17
			route_q.divider_tap_select <= (ctrl1_q[7:4] != `ACSEQ_SRC_LDO); // RL15
		end
	end

	// ****************************************************************
	// Interrupt
	// ****************************************************************
	// The request flag sets on completion whatever the enables; a set beats a same-cycle clear.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			int_status_q <= 1'b0;
		end else if (done_q) begin
			int_status_q <= 1'b1; // RL18
		end else if (wr_fire && aw_addr_q == `ACSEQ_OFS_INT_STATUS && w_lane0_q && w_data_q[`ACSEQ_IS_DONE]) begin
			int_status_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= int_status_q && int_mask_q && (&int_enable_q); // RL12
		end
	end

	// ****************************************************************
	// AXI4-Lite write channel
	// ****************************************************************
	// Address and data are taken in either order; the write fires once both are held.
	assign wr_fire   = !awready_q && !wready_q && !bvalid_q;
	assign map_hit_w = (aw_addr_q[1:0] == 2'h0) && (aw_addr_q <= `ACSEQ_OFS_INT_ENABLE);

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			bvalid_q  <= 1'b0;
			bresp_q   <= `ACSEQ_RESP_OKAY;
			aw_addr_q <= 8'h00;
			w_data_q  <= 32'h0000_0000;
			w_lane0_q <= 1'b0;
		end else begin
			if (awready_q && s_axi_awvalid) begin
				awready_q <= 1'b0;
				aw_addr_q <= s_axi_awaddr;
			end
			if (wready_q && s_axi_wvalid) begin
				wready_q  <= 1'b0;
				w_data_q  <= s_axi_wdata;
				w_lane0_q <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q  <= map_hit_w ? `ACSEQ_RESP_OKAY : `ACSEQ_RESP_SLVERR;
			end
			if (bvalid_q && s_axi_bready) begin
				bvalid_q  <= 1'b0;
				awready_q <= 1'b1;
				wready_q  <= 1'b1;
			end
		end
	end

	// Control registers; only byte lane 0 carries data, busy is read-only.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ctrl0_q      <= `ACSEQ_RST_CTRL0;
			ctrl1_q      <= `ACSEQ_RST_CTRL1;
			ctrl2_q      <= `ACSEQ_RST_CTRL2;
			int_mask_q   <= 1'b0;
			int_enable_q <= 3'h0;
		end else if (wr_fire && w_lane0_q) begin
			case (aw_addr_q)
				`ACSEQ_OFS_CTRL0:      ctrl0_q      <= w_data_q[7:0] & 8'hBF;
				`ACSEQ_OFS_CTRL1:      ctrl1_q      <= w_data_q[7:0] & 8'hF7;
				`ACSEQ_OFS_CTRL2:      ctrl2_q      <= w_data_q[7:0] & 8'h33;
				`ACSEQ_OFS_INT_MASK:   int_mask_q   <= w_data_q[`ACSEQ_IS_DONE];
				`ACSEQ_OFS_INT_ENABLE: int_enable_q <= w_data_q[2:0];
				default: begin
				end
			endcase
		end
	end

	// ****************************************************************
	// AXI4-Lite read channel
	// ****************************************************************
	assign map_hit_r = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr <= `ACSEQ_OFS_INT_ENABLE);

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= `ACSEQ_RESP_OKAY;
		end else if (arready_q && s_axi_arvalid) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rresp_q   <= map_hit_r ? `ACSEQ_RESP_OKAY : `ACSEQ_RESP_SLVERR;
			case (s_axi_araddr)
				`ACSEQ_OFS_CTRL0:      rdata_q <= {24'h000000, ctrl0_q[7], busy_q, ctrl0_q[5:0]}; // RL5
				`ACSEQ_OFS_CTRL1:      rdata_q <= {24'h000000, ctrl1_q};
				`ACSEQ_OFS_CTRL2:      rdata_q <= {24'h000000, ctrl2_q};
				`ACSEQ_OFS_RES_HIGH:   rdata_q <= {24'h000000, res_high_q}; // RL6
				`ACSEQ_OFS_RES_LOW:    rdata_q <= {24'h000000, res_low_q};
				`ACSEQ_OFS_INT_STATUS: rdata_q <= {31'h00000000, int_status_q};
				`ACSEQ_OFS_INT_MASK:   rdata_q <= {31'h00000000, int_mask_q};
				`ACSEQ_OFS_INT_ENABLE: rdata_q <= {29'h00000000, int_enable_q};
				default:               rdata_q <= 32'h0000_0000;
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q  <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign core_ctrl     = core_q;
	assign route         = route_q;
	assign irq           = irq_q;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	// Helper: converter ticks seen since launch, checked at completion.
	logic [4:0] tick_total_q;
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			tick_total_q <= 5'h00;
		end else if (!busy_q) begin
			tick_total_q <= 5'h00;
		end else if (tick) begin
			tick_total_q <= tick_total_q + 5'h01;
		end
	end

	default clocking cb_sys @(posedge clk_sys); endclocking
	default disable iff (reset);

	property p_sample_len;
		state_q == ACSEQ_SAMPLE && tick && phase_cnt_q == 4'h3 && power_bit && !start_bit |=> state_q == ACSEQ_CONVERT;
	endproperty
	a_sample_len: assert property (p_sample_len) else $error("sample phase length wrong"); // RL1

	property p_total_len;
		$rose(done_q) |-> $past(tick_total_q) == 5'h0F;
	endproperty
	a_total_len: assert property (p_total_len) else $error("conversion not sixteen ticks"); // RL2

	property p_busy;
		busy_q == (state_q == ACSEQ_SAMPLE || state_q == ACSEQ_CONVERT);
	endproperty
	a_busy: assert property (p_busy) else $error("busy flag mismatches state"); // RL5

	property p_done;
		done_q |-> !busy_q && $past(busy_q);
	endproperty
	a_done: assert property (p_done) else $error("completion without busy fall"); // RL6

	property p_format;
		done_q && format_bit |-> res_high_q[7:4] == 4'h0;
	endproperty
	a_format: assert property (p_format) else $error("right-aligned result high nibble set"); // RL11

	property p_irq;
		irq_q |-> $past(int_status_q) && $past(int_mask_q) && $past(int_enable_q) == 3'h7;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt without all enables"); // RL12

	property p_ext;
		route_q.ext_connect |-> !internal_src;
	endproperty
	a_ext: assert property (p_ext) else $error("external path connected for internal source"); // RL8

	property p_power;
		!power_bit |=> !core_q.power ##1 !busy_q;
	endproperty
	a_power: assert property (p_power) else $error("core powered while disabled"); // RL13

	property p_tap;
		!$past(reset) |-> route_q.divider_tap_select == ($past(ctrl1_q[7:4]) != 4'h8);
	endproperty
	a_tap: assert property (p_tap) else $error("tap select wrong"); // RL15

	property p_flag;
		done_q |=> int_status_q;
	endproperty
	a_flag: assert property (p_flag) else $error("request flag not set"); // RL18

	property p_launch;
		start_prev_q && !start_bit && state_q == ACSEQ_HOLD && power_bit |=> busy_q && state_q == ACSEQ_SAMPLE;
	endproperty
	a_launch: assert property (p_launch) else $error("falling start did not launch"); // RL19

endmodule

// ===== acseq_defs.svh
// Register offsets, field positions, reset values and phase counts of the conversion sequencer.
`ifndef ACSEQ_DEFS_SVH
`define ACSEQ_DEFS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ACSEQ_OFS_CTRL0       8'h00
`define ACSEQ_OFS_CTRL1       8'h04
`define ACSEQ_OFS_CTRL2       8'h08
`define ACSEQ_OFS_RES_HIGH    8'h0C
`define ACSEQ_OFS_RES_LOW     8'h10
`define ACSEQ_OFS_INT_STATUS  8'h14
`define ACSEQ_OFS_INT_MASK    8'h18
`define ACSEQ_OFS_INT_ENABLE  8'h1C

// ****************************************************************
// Field positions
// ****************************************************************
`define ACSEQ_C0_START        7
`define ACSEQ_C0_BUSY         6
`define ACSEQ_C0_POWER        5
`define ACSEQ_C0_FORMAT       4
`define ACSEQ_C0_CHAN_LSB     0
`define ACSEQ_C1_SRC_LSB      4
`define ACSEQ_C1_DIV_LSB      0
`define ACSEQ_C2_AMP_EN       5
`define ACSEQ_C2_AMP_IN       4
`define ACSEQ_C2_REF_LSB      0
`define ACSEQ_IE_GLOBAL       0
`define ACSEQ_IE_CONV         1
`define ACSEQ_IE_MULTI        2
`define ACSEQ_IS_DONE         0

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define ACSEQ_RST_CTRL0       8'h00
`define ACSEQ_RST_CTRL1       8'h00
`define ACSEQ_RST_CTRL2       8'h00
`define ACSEQ_SRC_LDO         4'h8
`define ACSEQ_RESP_OKAY       2'h0
`define ACSEQ_RESP_SLVERR     2'h2

// ****************************************************************
// Phase lengths in converter clock cycles
// ****************************************************************
`define ACSEQ_SAMPLE_CYCLES   4'h4
`define ACSEQ_CONVERT_CYCLES  4'hC
`define ACSEQ_TOTAL_CYCLES    5'h10

`endif

// ===== acseq_pkg.sv
// Types shared by the conversion sequencer and its users.
package acseq_pkg;

	// Sequencer states, Gray coded along idle, sample, convert.
	typedef enum logic [1:0] {
		ACSEQ_IDLE    = 2'h0,
		ACSEQ_SAMPLE  = 2'h1,
		ACSEQ_CONVERT = 2'h3,
		ACSEQ_HOLD    = 2'h2
	} acseq_state_type;

	// Timing strobes towards the analog converter core.
	typedef struct packed {
		logic power;
		logic reset;
		logic sample;
		logic convert;
		logic tick;
	} acseq_core_ctrl_type;

	// Routing of inputs and reference around the core.
	typedef struct packed {
		logic [3:0] source;
		logic [3:0] channel;
		logic       ext_connect;
		logic [1:0] reference;
		logic       amp_enable;
		logic       amp_input;
		logic       divider_tap_select;
	} acseq_route_type;

endpackage

// ===== acseq_core_model.sv
// Behavioural model of the analog converter core that faces the sequencer.
`timescale 1ns/100ps

module acseq_core_model (
	input  wire logic                          clk_sys,
	input  wire logic                          reset,
	input  wire acseq_pkg::acseq_core_ctrl_type core_ctrl,
	input  wire logic [11:0]                   level,
	output logic      [11:0]                   core_result
);
	import acseq_pkg::*;

	// ****************************************************************
	// Conversion output
	// ****************************************************************
	// The analog level reaches the output only while powered and converting.
	// Otherwise the output flips every cycle, so a capture taken at the wrong moment shows up.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			core_result <= 12'h5A5;
		end else if (core_ctrl.power && !core_ctrl.reset && core_ctrl.convert) begin
			core_result <= level;
		end else begin
			core_result <= ~core_result;
		end
	end
endmodule

// ===== testbench.sv
// Self-checking testbench of the conversion sequencer.
`timescale 1ns/100ps
`include "acseq_defs.svh"

module testbench;
	import acseq_pkg::*;

	logic                clk_sys = 1'b0;
	logic                reset   = 1'b1;
	logic [7:0]          awaddr  = 8'h00;
	logic                awvalid = 1'b0;
	logic                awready;
	logic [31:0]         wdata   = 32'h0;
	logic                wvalid  = 1'b0;
	logic                wready;
	logic [1:0]          bresp;
	logic                bvalid;
	logic                bready  = 1'b0;
	logic [7:0]          araddr  = 8'h00;
	logic                arvalid = 1'b0;
	logic                arready;
	logic [31:0]         rdata;
	logic [1:0]          rresp;
	logic                rvalid;
	logic                rready  = 1'b0;
	logic [11:0]         core_result;
	logic [11:0]         level   = 12'h000;
	acseq_core_ctrl_type core_ctrl;
	acseq_route_type     route;
	logic                irq;
	int                  fails = 0;
	int                  checks_done = 0;
	int                  samp_n = 0;
	int                  conv_n = 0;
	int                  tick_n = 0;

	// ****************************************************************
	// Clock, reset, design and core model
	// ****************************************************************
	always #5 clk_sys = ~clk_sys;

	acseq_top dut (.clk_sys(clk_sys), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .core_result(core_result),
		.core_ctrl(core_ctrl), .route(route), .irq(irq));

	acseq_core_model core (.clk_sys(clk_sys), .reset(reset), .core_ctrl(core_ctrl), .level(level),
		.core_result(core_result));

	// Phase lengths are counted in system clocks, so the divider shows in them.
	always @(posedge clk_sys) begin
		if (core_ctrl.sample === 1'b1) samp_n++;
		if (core_ctrl.convert === 1'b1) conv_n++;
		if (core_ctrl.tick === 1'b1 && (core_ctrl.sample === 1'b1 || core_ctrl.convert === 1'b1)) tick_n++;
	end

	// ****************************************************************
	// Comparison and bus tasks
	// ****************************************************************
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Address and data are offered together; each is dropped when taken, then the response is awaited.
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
		int  n;
		logic aw_p;
		logic w_p;
		n = 0;
		aw_p = 1'b1;
		w_p = 1'b1;
		@(posedge clk_sys);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {24'h0, d};
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (aw_p && awvalid && awready) begin
				aw_p = 1'b0;
				awvalid <= 1'b0;
			end
			if (w_p && wvalid && wready) begin
				w_p = 1'b0;
				wvalid <= 1'b0;
			end
		end while (!(bvalid && !aw_p && !w_p) && n < 100);
		resp = bresp;
		bready <= 1'b0;
		if (n >= 100) fails++;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		int  n;
		logic ar_p;
		n = 0;
		ar_p = 1'b1;
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (ar_p && arvalid && arready) begin
				ar_p = 1'b0;
				arvalid <= 1'b0;
			end
		end while (!(rvalid && !ar_p) && n < 100);
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
		if (n >= 100) fails++;
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	// Reset values, then refused offsets, which must answer with an error; only the unmapped read is also checked to read zero.
	task automatic t_reset;
		logic [31:0] d;
		logic [1:0]  r;
		for (int i = 0; i < 8; i++) begin
			rd(8'(i * 4), d, r);
			if (i != 3 && i != 4) check("reset value", d, 32'h0);
		end
		check("tap after reset", route.divider_tap_select, 1'b1);
		rd(8'h20, d, r);
		check("unmapped read", {d[29:0], r}, {30'h0, `ACSEQ_RESP_SLVERR});
		rd(8'h02, d, r);
		check("unaligned read", r, `ACSEQ_RESP_SLVERR);
		wr(8'h20, 8'hFF, r);
		check("unmapped write", r, `ACSEQ_RESP_SLVERR);
	endtask

	// Every source code is walked; only external codes may connect the channel path.
	task automatic t_route;
		logic [31:0] d;
		logic [1:0]  r;
		logic        ext;
		wr(`ACSEQ_OFS_CTRL0, 8'h25, r);
		for (int s = 0; s < 16; s++) begin
			wr(`ACSEQ_OFS_CTRL1, {4'(s), 4'h5}, r);
			repeat (2) @(posedge clk_sys);
			ext = (s == 0 || s == 4 || s >= 12);
			check("ext connect", route.ext_connect, ext);
			check("tap select", route.divider_tap_select, s != 8);
			check("source", {route.source, route.channel}, {4'(s), 4'h5});
		end
		rd(`ACSEQ_OFS_CTRL1, d, r);
		check("ctrl1 readback", d, 32'hF5);
		wr(`ACSEQ_OFS_CTRL2, 8'h31, r);
		repeat (2) @(posedge clk_sys);
		check("reference", {route.amp_enable, route.amp_input, route.reference}, 4'hD);
	endtask

	// One conversion at a given divider and format; the status flag is cleared afterwards if asked.
	task automatic t_convert(input logic [2:0] dv, input logic fmt, input logic [11:0] lv, input logic clr);
		logic [31:0] d;
		logic [1:0]  r;
		int          n;
		level <= lv;
		wr(`ACSEQ_OFS_CTRL1, {5'h0, dv}, r);
		wr(`ACSEQ_OFS_CTRL0, {3'b101, fmt, 4'h0}, r);
		@(posedge clk_sys);
		check("core reset on start", core_ctrl.reset, 1'b1);
		samp_n = 0;
		conv_n = 0;
		tick_n = 0;
		wr(`ACSEQ_OFS_CTRL0, {3'b001, fmt, 4'h0}, r);
		rd(`ACSEQ_OFS_CTRL0, d, r);
		check("busy after launch", d[6], 1'b1);
		n = 0;
		do begin
			rd(`ACSEQ_OFS_CTRL0, d, r);
			n++;
		end while (d[6] && n < 2000);
		check("busy cleared", d[6], 1'b0);
		check("sample length", samp_n, 4 << dv);
		check("convert length", conv_n, 12 << dv);
		check("total length", samp_n + conv_n, 16 << dv);
		check("tick count", tick_n, 16);
		rd(`ACSEQ_OFS_RES_HIGH, d, r);
		check("result high", d, fmt ? {28'h0, lv[11:8]} : {24'h0, lv[11:4]});
		rd(`ACSEQ_OFS_RES_LOW, d, r);
		check("result low", d, fmt ? {24'h0, lv[7:0]} : {24'h0, lv[3:0], 4'h0});
		rd(`ACSEQ_OFS_INT_STATUS, d, r);
		check("done flag", d, 32'h1);
		if (clr) begin
			wr(`ACSEQ_OFS_INT_STATUS, 8'h01, r);
			rd(`ACSEQ_OFS_INT_STATUS, d, r);
			check("flag cleared", d, 32'h0);
		end
	endtask

	// The interrupt needs the mask and all three enables; the table drops one of them at a time.
	task automatic t_irq;
		logic [3:0]  tab [6] = '{4'hB, 4'hF, 4'h7, 4'hE, 4'hD, 4'hF};
		logic [1:0]  r;
		wr(`ACSEQ_OFS_INT_ENABLE, 8'h03, r);
		wr(`ACSEQ_OFS_INT_MASK, 8'h01, r);
		t_convert(3'h1, 1'b1, 12'h9C3, 1'b0);
		for (int i = 0; i < 6; i++) begin
			wr(`ACSEQ_OFS_INT_MASK, {7'h0, tab[i][3]}, r);
			wr(`ACSEQ_OFS_INT_ENABLE, {5'h0, tab[i][2:0]}, r);
			repeat (3) @(posedge clk_sys);
			check("irq level", irq, &tab[i]);
		end
		wr(`ACSEQ_OFS_INT_STATUS, 8'h01, r);
		repeat (3) @(posedge clk_sys);
		check("irq after clear", irq, 1'b0);
	endtask

	// A start in mid-conversion aborts it; a start without power does nothing.
	task automatic t_abort;
		logic [31:0] d;
		logic [1:0]  r;
		wr(`ACSEQ_OFS_CTRL0, 8'hA0, r);
		wr(`ACSEQ_OFS_CTRL0, 8'h20, r);
		repeat (5) @(posedge clk_sys);
		wr(`ACSEQ_OFS_CTRL0, 8'hA0, r);
		rd(`ACSEQ_OFS_CTRL0, d, r);
		check("aborted busy", d[6], 1'b0);
		repeat (40) @(posedge clk_sys);
		rd(`ACSEQ_OFS_INT_STATUS, d, r);
		check("no flag on abort", d, 32'h0);
		wr(`ACSEQ_OFS_CTRL0, 8'h80, r);
		wr(`ACSEQ_OFS_CTRL0, 8'h00, r);
		rd(`ACSEQ_OFS_CTRL0, d, r);
		check("unpowered busy", d[6], 1'b0);
		check("core power off", {core_ctrl.power, route.ext_connect}, 2'b00);
	endtask

	// ****************************************************************
	// Main sequence and watchdog
	// ****************************************************************
	task automatic end_sim;
		if (fails == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge clk_sys);
		reset <= 1'b0;
		t_reset();
		t_route();
		for (int dv = 0; dv < 8; dv++) begin
			t_convert(3'(dv), dv[0], 12'hFFF ^ {3'(dv), 3'(dv), 3'(dv), 3'(dv)}, 1'b1);
		end
		t_irq();
		t_abort();
		end_sim();
	end

	// The longest conversion takes about 2000 clocks; the whole run stays far below this span.
	initial begin
		#(60000 * 10);
		fails++;
		end_sim();
	end
endmodule
